//--- design/pie_cfg.svh
// register offsets, field positions, reset values for the peripheral enable bank
`ifndef PIE_CFG_SVH
`define PIE_CFG_SVH

// register indices; byte address is four times the index
`define PIE_IDX_INT_CTRL 8'h07
`define PIE_IDX_CORE_CTRL 8'h08
`define PIE_IDX_BANK_SEL 8'h0f
`define PIE_IDX_FLAG_ONE 8'h16
`define PIE_IDX_ENABLE_ONE 8'h17
`define PIE_IDX_EVT_STATUS 8'h20
`define PIE_IDX_EVT_MASK 8'h21

`define PIE_BANK_ONE 4'h1

// enable / flag bit positions
`define PIE_BIT_CHANGE_PORT 7
`define PIE_BIT_TIMER_THREE 6
`define PIE_BIT_TIMER_TWO 5
`define PIE_BIT_TIMER_ONE 4
`define PIE_BIT_CAPTURE_TWO 3
`define PIE_BIT_CAPTURE_ONE 2
`define PIE_BIT_SERIAL_TX 1
`define PIE_BIT_SERIAL_RX 0

// control field positions
`define PIE_BIT_PENDING 7
`define PIE_BIT_GROUP_EN 3
`define PIE_BIT_GLOBAL_DIS 0

// reset values
`define PIE_RST_ENABLE 8'h00
`define PIE_RST_FLAG 8'h00
`define PIE_RST_GROUP_EN 1'b0
`define PIE_RST_GLOBAL_DIS 1'b1
`define PIE_RST_BANK 4'h0
`define PIE_RST_EVT 8'h00
`define PIE_RST_MASK 8'h00

`endif

//--- design/pie_enable_bank.sv
// peripheral interrupt enable bank one with apb register access
`timescale 1ns/1ps
`include "pie_cfg.svh"

module pie_enable_bank (
  input wire logic clk, // 50 mhz core clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped access
  input wire logic [7:0] src_evt, // per-source trigger pulses, same clock
  output logic periph_irq_req, // peripheral interrupt request to core
  output logic periph_pending, // or of enabled pending flags
  output logic irq // block event interrupt, level
);

  logic [7:0] enable_ff;
  logic [7:0] flag_ff;
  logic group_en_ff;
  logic global_dis_ff;
  logic [3:0] bank_ff;
  logic [7:0] evt_ff;
  logic [7:0] mask_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [7:0] nxt_enable;
  logic [7:0] nxt_flag;
  logic [7:0] nxt_evt;
  logic [31:0] nxt_rdata;
  logic setup_phase;
  logic done;
  logic wr_done;
  logic rd_done;
  logic wr_lane0;
  pie_pkg::pie_reg_t acc_reg;
  logic [7:0] gated_flags;

  // word decode; banked registers only answer while bank one is selected
  function automatic pie_pkg::pie_reg_t reg_decode(
    input logic [11:0] addr,
    input logic [3:0] bank
  );
    pie_pkg::pie_reg_t sel;
    logic [7:0] idx;
    sel = pie_pkg::PIE_REG_NONE;
    idx = addr[9:2];
    if (addr[1:0] != 2'h0 || addr[11:10] != 2'h0) begin
      sel = pie_pkg::PIE_REG_NONE;
    end else if (idx == `PIE_IDX_INT_CTRL) begin
      sel = pie_pkg::PIE_REG_INT_CTRL;
    end else if (idx == `PIE_IDX_CORE_CTRL) begin
      sel = pie_pkg::PIE_REG_CORE_CTRL;
    end else if (idx == `PIE_IDX_BANK_SEL) begin
      sel = pie_pkg::PIE_REG_BANK_SEL;
    end else if (idx == `PIE_IDX_FLAG_ONE && bank == `PIE_BANK_ONE) begin
      sel = pie_pkg::PIE_REG_FLAG_ONE;
    end else if (idx == `PIE_IDX_ENABLE_ONE && bank == `PIE_BANK_ONE) begin
      sel = pie_pkg::PIE_REG_ENABLE_ONE;
    end else if (idx == `PIE_IDX_EVT_STATUS) begin
      sel = pie_pkg::PIE_REG_EVT_STATUS;
    end else if (idx == `PIE_IDX_EVT_MASK) begin
      sel = pie_pkg::PIE_REG_EVT_MASK;
    end
    return sel;
  endfunction : reg_decode

  // zero wait states: read data and error are captured in the setup cycle
  assign setup_phase = psel && !penable;
  assign pready = psel && penable;
  assign done = psel && penable;
  assign wr_done = done && pwrite && !pslverr_ff;
  assign rd_done = done && !pwrite && !pslverr_ff;
  assign wr_lane0 = wr_done && pstrb[0];
  assign acc_reg = reg_decode(paddr, bank_ff);
  assign prdata = prdata_ff;
  assign pslverr = pready && pslverr_ff;

  // each source gated only by its own enable bit
  assign gated_flags = flag_ff & enable_ff;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (acc_reg == pie_pkg::PIE_REG_INT_CTRL) begin
      nxt_rdata[`PIE_BIT_PENDING] = |gated_flags;
      nxt_rdata[`PIE_BIT_GROUP_EN] = group_en_ff;
    end else if (acc_reg == pie_pkg::PIE_REG_CORE_CTRL) begin
      nxt_rdata[`PIE_BIT_GLOBAL_DIS] = global_dis_ff;
    end else if (acc_reg == pie_pkg::PIE_REG_BANK_SEL) begin
      nxt_rdata[3:0] = bank_ff;
    end else if (acc_reg == pie_pkg::PIE_REG_FLAG_ONE) begin
      nxt_rdata[7:0] = flag_ff;
    end else if (acc_reg == pie_pkg::PIE_REG_ENABLE_ONE) begin
      nxt_rdata[7:0] = enable_ff;
    end else if (acc_reg == pie_pkg::PIE_REG_EVT_STATUS) begin
      nxt_rdata[7:0] = evt_ff;
    end else if (acc_reg == pie_pkg::PIE_REG_EVT_MASK) begin
      nxt_rdata[7:0] = mask_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup_phase) begin
      prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
      pslverr_ff <= (acc_reg == pie_pkg::PIE_REG_NONE);
    end
  end

  // enable register: every bit plain read-write
  always_comb begin
    nxt_enable = enable_ff;
    if (wr_lane0 && acc_reg == pie_pkg::PIE_REG_ENABLE_ONE) begin
      nxt_enable[`PIE_BIT_CHANGE_PORT] = pwdata[`PIE_BIT_CHANGE_PORT];
      nxt_enable[`PIE_BIT_TIMER_THREE] = pwdata[`PIE_BIT_TIMER_THREE];
      nxt_enable[`PIE_BIT_TIMER_TWO] = pwdata[`PIE_BIT_TIMER_TWO];
      nxt_enable[`PIE_BIT_TIMER_ONE] = pwdata[`PIE_BIT_TIMER_ONE];
      nxt_enable[`PIE_BIT_CAPTURE_TWO] = pwdata[`PIE_BIT_CAPTURE_TWO];
      nxt_enable[`PIE_BIT_CAPTURE_ONE] = pwdata[`PIE_BIT_CAPTURE_ONE];
      nxt_enable[`PIE_BIT_SERIAL_TX] = pwdata[`PIE_BIT_SERIAL_TX];
      nxt_enable[`PIE_BIT_SERIAL_RX] = pwdata[`PIE_BIT_SERIAL_RX];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_ff <= `PIE_RST_ENABLE;
    end else begin
      enable_ff <= nxt_enable;
    end
  end

  // flags: software may write them, but a trigger in the same cycle wins
  always_comb begin
    nxt_flag = flag_ff;
    if (wr_lane0 && acc_reg == pie_pkg::PIE_REG_FLAG_ONE) begin
      nxt_flag = pwdata[7:0];
    end
    nxt_flag = nxt_flag | src_evt;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_ff <= `PIE_RST_FLAG;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      group_en_ff <= `PIE_RST_GROUP_EN;
      global_dis_ff <= `PIE_RST_GLOBAL_DIS;
      bank_ff <= `PIE_RST_BANK;
    end else if (wr_lane0) begin
      if (acc_reg == pie_pkg::PIE_REG_INT_CTRL) begin
        group_en_ff <= pwdata[`PIE_BIT_GROUP_EN];
      end else if (acc_reg == pie_pkg::PIE_REG_CORE_CTRL) begin
        global_dis_ff <= pwdata[`PIE_BIT_GLOBAL_DIS];
      end else if (acc_reg == pie_pkg::PIE_REG_BANK_SEL) begin
        bank_ff <= pwdata[3:0];
      end
    end
  end

  // sticky event bits record each trigger; a read clears only what it returned,
  // so an event landing after the setup-cycle capture is not lost
  always_comb begin
    nxt_evt = evt_ff;
    if (rd_done && acc_reg == pie_pkg::PIE_REG_EVT_STATUS) begin
      nxt_evt = evt_ff & ~prdata_ff[7:0];
    end
    nxt_evt = nxt_evt | src_evt;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      evt_ff <= `PIE_RST_EVT;
    end else begin
      evt_ff <= nxt_evt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_ff <= `PIE_RST_MASK;
    end else if (wr_lane0 && acc_reg == pie_pkg::PIE_REG_EVT_MASK) begin
      mask_ff <= pwdata[7:0];
    end
  end

  // group enable and global disable only gate the request, never the flags
  assign periph_pending = |gated_flags;
  assign periph_irq_req = periph_pending && group_en_ff && !global_dis_ff;
  assign irq = |(evt_ff & mask_ff);

endmodule : pie_enable_bank

//--- design/pie_pkg.sv
// types shared by the peripheral enable bank
package pie_pkg;

  typedef enum logic [2:0] {
    PIE_REG_NONE = 3'h0,
    PIE_REG_INT_CTRL = 3'h1,
    PIE_REG_CORE_CTRL = 3'h2,
    PIE_REG_BANK_SEL = 3'h3,
    PIE_REG_FLAG_ONE = 3'h4,
    PIE_REG_ENABLE_ONE = 3'h5,
    PIE_REG_EVT_STATUS = 3'h6,
    PIE_REG_EVT_MASK = 3'h7
  } pie_reg_t;

endpackage : pie_pkg

//--- tb/pie_enable_bank_monitor.sv
// port checker for the peripheral enable bank
`timescale 1ns/1ps
module pie_enable_bank_monitor (
  input wire logic clk, // clock
  input wire logic sys_rst, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [11:0] paddr, // apb
  input wire logic [31:0] pwdata, // apb
  input wire logic [3:0] pstrb, // apb
  input wire logic [31:0] prdata, // apb
  input wire logic pready, // apb
  input wire logic pslverr, // apb
  input wire logic [7:0] src_evt, // events
  input wire logic periph_irq_req, // request
  input wire logic periph_pending, // pending
  input wire logic irq // event irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_ready; pready == (psel && penable); endproperty
  a_ready: assert property (p_ready) else $error("pready outside access");
  property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("bad refused access");
  property p_req; periph_irq_req |-> periph_pending; endproperty
  a_req: assert property (p_req) else $error("request without pending");
  property p_rst; $fell(sys_rst) |-> !periph_pending && !periph_irq_req && !irq; endproperty
  a_rst: assert property (p_rst) else $error("outputs high after reset");
  property p_hold;
    !(psel && penable) && src_evt == 8'h00 |=> $stable(periph_pending) && $stable(irq);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved without cause");
  property p_fall; $fell(periph_pending) |-> $past(psel && penable && pwrite || sys_rst); endproperty
  a_fall: assert property (p_fall) else $error("pending lost without write");
  property p_rise; $rose(periph_pending) |-> $past(src_evt != 8'h00 || pwrite && pready); endproperty
  a_rise: assert property (p_rise) else $error("pending rose without cause");
  property p_irq; $rose(irq) |-> $past(src_evt != 8'h00 || pwrite && pready); endproperty
  a_irq: assert property (p_irq) else $error("irq rose without cause");
endmodule : pie_enable_bank_monitor
bind pie_enable_bank pie_enable_bank_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_evt(src_evt),
  .periph_irq_req(periph_irq_req), .periph_pending(periph_pending), .irq(irq));

//--- tb/pie_enable_bank_test.sv
// self-checking bench for the peripheral enable bank
`timescale 1ns/1ps
module pie_enable_bank_test;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
  logic [3:0] pstrb = 4'hf;
  logic [7:0] src_evt = 8'h00, setup_evt = 8'h00;
  logic pready, pslverr, periph_irq_req, periph_pending, irq;
  int num_errors = 0, total_checks = 0, cyc = 0;
  int en = 0, fl = 0, grp = 0, gdis = 1, ev = 0, msk = 0;
  always #10 clk = ~clk;
  pie_enable_bank dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_evt(src_evt), .periph_irq_req(periph_irq_req),
    .periph_pending(periph_pending), .irq(irq));
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    src_evt <= setup_evt;
    @(posedge clk);
    penable <= 1'b1;
    src_evt <= 8'h00;
    setup_evt = 8'h00;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic outs;
    @(negedge clk);
    check("pending", periph_pending, (en & fl) != 0);
    check("request", periph_irq_req, (en & fl) != 0 && grp != 0 && gdis == 0);
    check("irq", irq, (ev & msk) != 0);
    @(posedge clk);
  endtask : outs
  task automatic pulse(input logic [7:0] e);
    src_evt <= e;
    @(posedge clk);
    src_evt <= 8'h00;
    fl |= e;
    ev |= e;
    outs();
  endtask : pulse
  initial begin
    void'($urandom(6));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    apb(0, 12'h05c, 0);
    check("bank err", er, 1);
    apb(0, 12'h100, 0);
    check("unmapped err", er, 1);
    apb(1, 12'h03c, 1);
    apb(0, 12'h05c, 0);
    check("enable reset", rd, 0);
    en = $urandom;
    apb(1, 12'h05c, en);
    en &= 8'hff;
    apb(0, 12'h05c, 0);
    check("enable rw", rd, en);
    pstrb <= 4'he;
    apb(1, 12'h05c, ~en);
    pstrb <= 4'hf;
    apb(0, 12'h05c, 0);
    check("strobe off", rd, en);
    apb(1, 12'h05c, 0);
    en = 0;
    pulse(8'hff);
    apb(0, 12'h058, 0);
    check("flags", rd, 8'hff);
    apb(1, 12'h01c, 8);
    grp = 1;
    apb(1, 12'h020, 0);
    gdis = 0;
    for (int i = 0; i < 8; i++) begin
      apb(1, 12'h058, 0);
      apb(1, 12'h05c, 1 << i);
      fl = 0;
      en = 1 << i;
      pulse(8'hff ^ (8'h01 << i));
      pulse(8'h01 << i);
      check("gated", periph_irq_req, 1);
    end
    apb(0, 12'h01c, 0);
    check("int ctrl", rd, {24'h00_0000, (en & fl) != 0, 3'h0, grp[0], 3'h0});
    apb(1, 12'h020, 1);
    gdis = 1;
    apb(0, 12'h020, 0);
    check("core ctrl", rd, gdis);
    outs();
    apb(1, 12'h020, 0);
    gdis = 0;
    apb(1, 12'h01c, 0);
    grp = 0;
    outs();
    apb(1, 12'h084, 8'h0f);
    msk = 8'h0f;
    pulse(8'h02);
    apb(0, 12'h080, 0);
    check("status", rd, ev);
    ev = 0;
    outs();
    // an event in the setup cycle of a clearing read must survive that read
    setup_evt = 8'h04;
    apb(0, 12'h080, 0);
    check("status race", rd, ev);
    ev = 8'h04;
    outs();
    apb(0, 12'h080, 0);
    check("status kept", rd, ev);
    ev = 0;
    outs();
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    en = 0;
    fl = 0;
    grp = 0;
    gdis = 1;
    msk = 0;
    @(posedge clk);
    outs();
    apb(0, 12'h03c, 0);
    check("bank reset", rd, 0);
    apb(0, 12'h05c, 0);
    check("reset bank err", er, 1);
    end_sim();
  end
endmodule : pie_enable_bank_test
